// File: rco_ref_clock.sv
`timescale 1ns/100ps
`default_nettype none
// Reference clock output with APB register access
module rco_ref_clock
  import rco_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire logic                     sleep,
  input  wire logic                     system_osc,
  input  wire logic                     high_freq_internal_osc,
  input  wire logic                     low_freq_internal_osc,
  input  wire logic                     medium_freq_internal_osc_500k,
  input  wire logic                     medium_freq_internal_osc_32k,
  input  wire logic                     secondary_osc,
  input  wire logic                     external_osc,
  input  wire logic                     osc_controlled_output,
  input  wire logic                     logic_cell_one_output,
  input  wire logic                     logic_cell_two_output,
  input  wire logic                     logic_cell_three_output,
  input  wire logic                     logic_cell_four_output,
  output logic                          ref_clock_out_pin,
  output logic                          ref_clock_internal
);
  import rco_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic       en_q;
  logic [1:0] dc_q;
  logic [2:0] div_q;
  logic [3:0] sel_q;
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;
  logic       pin_q;
  logic       int_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic        setup_phase;
  wire logic        access_done;
  wire logic        hit_control;
  wire logic        hit_source;
  wire logic        mapped;
  wire logic        wr_control;
  wire logic        wr_source;
  wire logic [31:0] read_word;
  wire logic        shaper_active;
  wire logic        shaper_wave;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_q;
  assign hit_control = paddr[RCO_ADDR_W-1:0] == RCO_ADDR_CONTROL && paddr[31:RCO_ADDR_W] == '0;
  assign hit_source  = paddr[RCO_ADDR_W-1:0] == RCO_ADDR_SOURCE && paddr[31:RCO_ADDR_W] == '0;
  assign mapped      = hit_control || hit_source;
  // Only the low byte lane carries register bits
  assign wr_control  = access_done && pwrite && hit_control && pstrb[0];
  assign wr_source   = access_done && pwrite && hit_source && pstrb[0];

  // Reserved bits read zero; source word also shows the running state
  assign read_word = hit_control
                   ? {24'h0, en_q, 2'h0, dc_q, div_q}
                   : hit_source
                   ? {24'h0, shaper_active, 3'h0, sel_q}
                   : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake, no wait states; pready is registered from the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase && !mapped;
      prdata_q  <= (setup_phase && !pwrite) ? read_word : 32'h0;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q  <= RCO_EN_RESET;
      dc_q  <= RCO_DC_RESET;
      div_q <= RCO_DIV_RESET;
    end else if (wr_control) begin
      en_q  <= pwdata[RCO_EN_BIT];
      dc_q  <= pwdata[RCO_DC_HI:RCO_DC_LO];
      div_q <= pwdata[RCO_DIV_HI:RCO_DIV_LO];
    end
  end

  // Source select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= RCO_SEL_RESET;
    end else if (wr_source) begin
      sel_q <= pwdata[RCO_SEL_HI:RCO_SEL_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base clock selection
  logic base_sel;
  always_comb begin
    base_sel = 1'b0;
    case (sel_q)
      RCO_SRC_SYSTEM:   base_sel = system_osc;
      RCO_SRC_HFINT:    base_sel = high_freq_internal_osc;
      RCO_SRC_LFINT:    base_sel = low_freq_internal_osc;
      RCO_SRC_MF500K:   base_sel = medium_freq_internal_osc_500k;
      RCO_SRC_MF32K:    base_sel = medium_freq_internal_osc_32k;
      RCO_SRC_SECOND:   base_sel = secondary_osc;
      RCO_SRC_EXTERNAL: base_sel = external_osc;
      RCO_SRC_OSCCTL:   base_sel = osc_controlled_output;
      RCO_SRC_CELL1:    base_sel = logic_cell_one_output;
      RCO_SRC_CELL2:    base_sel = logic_cell_two_output;
      RCO_SRC_CELL3:    base_sel = logic_cell_three_output;
      RCO_SRC_CELL4:    base_sel = logic_cell_four_output;
      default:          base_sel = 1'b0;
    endcase
  end

  // Run condition: enabled, legal source, and not the system clock in sleep
  wire logic src_legal;
  wire logic sleep_stop;
  wire logic run;
  assign src_legal  = sel_q <= RCO_SRC_LAST;
  assign sleep_stop = sleep && sel_q == RCO_SRC_SYSTEM;
  assign run        = en_q && src_legal && !sleep_stop;

  rco_shaper #(
    .CNT_W (CNT_W)
  ) u_shaper (
    .pclk    (pclk),
    .presetn (presetn),
    .base    (base_sel),
    .run     (run),
    .div     (div_q),
    .dc      (dc_q),
    .wave    (shaper_wave),
    .active  (shaper_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output flops; gated by run so a disable lands on the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      pin_q <= run && shaper_wave;
      int_q <= run && shaper_wave;
    end
  end

  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign prdata             = prdata_q;
  assign ref_clock_out_pin  = pin_q;
  assign ref_clock_internal = int_q;

endmodule // rco_ref_clock
`default_nettype wire

// File: rco_pkg.sv
// Contract
// - Generated reference clock drives the dedicated output pin.
// - Same clock is offered internally to timers and logic cells.
// - Four-bit selector codes 0000..1011 pick the twelve listed base sources.
// - Source selector lives in bits 3:0 of the source select register.
// - Setting enable starts the output with no glitch or runt pulse.
// - Clearing enable stops the output at once, mid-period.
// - Enable is bit 7 of the control register; 1 on, 0 off.
// - Divider field divides the base clock by two to the field value.
// - Nonzero divider: duty field gives 0, 25, 50 or 75 percent high.
// - Zero divider: always 50 percent, except duty 00 holds output low.
// - Duty field is bits 4:3, divider field bits 2:0 of control register.
// - Duty field resets to 10, a 50 percent default.
// - In sleep the output keeps running except with the system clock source.
package rco_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] RCO_IDX_CONTROL = 12'h296;
  localparam logic [11:0] RCO_IDX_SOURCE  = 12'h297;
  localparam int          RCO_ADDR_W      = 14;
  localparam logic [13:0] RCO_ADDR_CONTROL = {RCO_IDX_CONTROL, 2'h0};
  localparam logic [13:0] RCO_ADDR_SOURCE  = {RCO_IDX_SOURCE, 2'h0};

  // Control register fields
  localparam int RCO_EN_BIT  = 7;
  localparam int RCO_DC_HI   = 4;
  localparam int RCO_DC_LO   = 3;
  localparam int RCO_DIV_HI  = 2;
  localparam int RCO_DIV_LO  = 0;
  // Source register fields
  localparam int RCO_SEL_HI  = 3;
  localparam int RCO_SEL_LO  = 0;
  localparam int RCO_RUN_BIT = 7;

  // Reset values
  localparam logic       RCO_EN_RESET  = 1'b0;
  localparam logic [1:0] RCO_DC_RESET  = 2'h2;
  localparam logic [2:0] RCO_DIV_RESET = 3'h0;
  localparam logic [3:0] RCO_SEL_RESET = 4'h0;

  // Duty codes
  localparam logic [1:0] RCO_DC_ZERO = 2'h0;
  localparam logic [1:0] RCO_DC_HALF = 2'h2;

  // Source selector codes
  typedef enum logic [3:0] {
    RCO_SRC_SYSTEM   = 4'b0000,
    RCO_SRC_HFINT    = 4'b0001,
    RCO_SRC_LFINT    = 4'b0010,
    RCO_SRC_MF500K   = 4'b0011,
    RCO_SRC_MF32K    = 4'b0100,
    RCO_SRC_SECOND   = 4'b0101,
    RCO_SRC_EXTERNAL = 4'b0110,
    RCO_SRC_OSCCTL   = 4'b0111,
    RCO_SRC_CELL1    = 4'b1000,
    RCO_SRC_CELL2    = 4'b1001,
    RCO_SRC_CELL3    = 4'b1010,
    RCO_SRC_CELL4    = 4'b1011
  } rco_src_e;

  localparam logic [3:0] RCO_SRC_LAST = 4'b1011;

endpackage

// File: rco_shaper.sv
`timescale 1ns/100ps
`default_nettype none
// Divider and duty shaper stepping on both edges of the base clock
module rco_shaper
  import rco_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       base,
  input  wire logic       run,
  input  wire logic [2:0] div,
  input  wire logic [1:0] dc,
  output logic            wave,
  output logic            active
);

  logic             base_q;
  logic [CNT_W-1:0] half_q;
  logic [CNT_W-1:0] half_d;
  logic             active_q;
  logic             wave_q;
  logic [2:0]       div_q;
  logic [1:0]       dc_q;
  wire logic             edge_seen;
  wire logic [CNT_W-1:0] period_last;
  wire logic [CNT_W-1:0] high_halves;
  wire logic             wrap;

  // Halves per period minus one: two to the divider, doubled
  function automatic logic [CNT_W-1:0] halves_last(input logic [2:0] d);
    halves_last = CNT_W'((1 << (d + 1)) - 1);
  endfunction

  // High halves per period for the duty code
  function automatic logic [CNT_W-1:0] halves_high(input logic [2:0] d, input logic [1:0] c);
    logic [CNT_W+1:0] prod;
    prod = {2'h0, halves_last(d)} + 1'b1;
    prod = prod * c;
    halves_high = prod[CNT_W+1:2];
  endfunction

  // High halves for given settings; undivided base stays 50 percent unless duty is off
  function automatic logic [CNT_W-1:0] halves_on(input logic [2:0] d, input logic [1:0] c);
    if (d == RCO_DIV_RESET) begin
      halves_on = (c == RCO_DC_ZERO) ? '0 : CNT_W'(1);
    end else begin
      halves_on = halves_high(d, c);
    end
  endfunction

  assign edge_seen   = base != base_q;
  assign period_last = halves_last(div_q);
  // High halves of the running period, from the latched settings
  assign high_halves = halves_on(div_q, dc_q);
  assign wrap        = half_q == period_last;
  assign half_d      = wrap ? '0 : half_q + 1'b1;

  // Base edge tracker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= 1'b0;
    end else begin
      base_q <= base;
    end
  end

  // Start only on a base rising edge, so the first high phase is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
      half_q   <= '0;
      div_q    <= RCO_DIV_RESET;
      dc_q     <= RCO_DC_RESET;
      wave_q   <= 1'b0;
    end else if (!run) begin
      active_q <= 1'b0;
      half_q   <= '0;
      wave_q   <= 1'b0;
    end else if (!active_q) begin
      div_q <= div;
      dc_q  <= dc;
      if (edge_seen && base) begin
        active_q <= 1'b1;
        half_q   <= '0;
        // Latched copy still holds the last run's settings, so use the live ones
        wave_q   <= halves_on(div, dc) != '0;
      end
    end else if (edge_seen) begin
      // Live settings follow at period boundaries only
      half_q <= half_d;
      if (wrap) begin
        div_q <= div;
        dc_q  <= dc;
      end
      // A new period opens with the settings that it latches
      wave_q <= wrap ? (halves_on(div, dc) != '0) : (half_d < high_halves);
    end
  end

  assign wave   = wave_q;
  assign active = active_q;

endmodule // rco_shaper
`default_nettype wire

// File: rco_ref_clock_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the reference clock output
module rco_ref_clock_properties
  import rco_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sleep,
  input wire logic        ref_clock_out_pin,
  input wire logic        ref_clock_internal
);
  logic       acc, at_ctl, at_src, calm, off;
  logic [7:0] ctl_q;
  logic [3:0] sel_q;
  logic [3:0] quiet_q;
  logic       sleep_q;

  // Decode of taken writes; a write with pstrb[0] low changes nothing
  assign acc    = psel && penable && pready && pwrite && pstrb[0];
  assign at_ctl = (paddr == {18'h0, RCO_ADDR_CONTROL});
  assign at_src = (paddr == {18'h0, RCO_ADDR_SOURCE});
  assign calm   = (quiet_q >= 4'h6);
  assign off    = !ctl_q[RCO_EN_BIT] || (sel_q > RCO_SRC_LAST);

  // Shadow settings; quiet counts cycles since a setting or sleep moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q   <= {RCO_EN_RESET, 2'h0, RCO_DC_RESET, RCO_DIV_RESET};
      sel_q   <= RCO_SEL_RESET;
      quiet_q <= 4'h0;
      sleep_q <= 1'b0;
    end else begin
      // Bits 6:5 are reserved and read zero
      ctl_q   <= (acc && at_ctl) ? (pwdata[7:0] & 8'h9f) : ctl_q;
      sel_q   <= (acc && at_src) ? pwdata[3:0] : sel_q;
      sleep_q <= sleep;
      quiet_q <= (acc || sleep != sleep_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PIN_COPY: assert property (ref_clock_out_pin == ref_clock_internal)
    else $error("pin and internal copy differ");
  AST_UNMAPPED_ERR: assert property (pready |-> pslverr == !(at_ctl || at_src))
    else $error("error response does not match the address");
  AST_CTRL_READBACK: assert property (pready && !pwrite && at_ctl |-> prdata == {24'h0, ctl_q})
    else $error("control read differs from last write");
  AST_DISABLE_NOW: assert property (acc && at_ctl && !pwdata[7] |-> ##2 (!ref_clock_out_pin) [*4])
    else $error("output still running after disable");
  AST_OFF_LOW: assert property (calm && off |-> !ref_clock_out_pin)
    else $error("output moves while off or reserved");
  AST_DUTY_ZERO_LOW: assert property (calm && ctl_q[4:3] == RCO_DC_ZERO |-> !ref_clock_out_pin)
    else $error("output moves with zero duty");
  AST_SLEEP_SYSTEM: assert property (calm && sleep && sel_q == 4'h0 |-> !ref_clock_out_pin)
    else $error("system clock source runs in sleep");
  AST_NO_RUNT: assert property ($rose(ref_clock_out_pin) |=> ref_clock_out_pin)
    else $error("one cycle runt pulse");

  // Main scenarios reached
  COV_ENABLE: cover property (acc && at_ctl && pwdata[7]);
  COV_SLEEP_RUN: cover property (sleep && $rose(ref_clock_out_pin));
  COV_ERROR: cover property (pready && pslverr);
endmodule // rco_ref_clock_properties
`default_nettype wire

// File: rco_load.sv
`timescale 1ns/100ps
`default_nettype none
// Pin load; times each period and high phase in pclk cycles
module rco_load (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pin,
  input  wire logic        internal,
  output logic      [15:0] high_len,
  output logic      [15:0] per_len,
  output logic      [15:0] rises
);
  logic        both, prev_q;
  logic [15:0] cnt_q, hcnt_q;

  // Both copies must be high to count, so a dead copy stops the rise count and fails the rise wait
  assign both = pin && internal;

  // A period runs from one rising edge to the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {prev_q, cnt_q, hcnt_q, high_len, per_len, rises} <= '0;
    end else begin
      prev_q <= both;
      cnt_q  <= (both && !prev_q) ? 16'h1 : cnt_q + 16'h1;
      hcnt_q <= (both && !prev_q) ? 16'h1 : hcnt_q + {15'h0, both};
      if (both && !prev_q) begin
        per_len  <= cnt_q;
        high_len <= hcnt_q;
        rises    <= rises + 16'h1;
      end
    end
  end
endmodule // rco_load
`default_nettype wire

// File: rco_ref_clock_test.sv
`timescale 1ns/100ps
`default_nettype none
module rco_ref_clock_test;
  import rco_pkg::*;
  typedef struct packed {
    logic [3:0]  sel;
    logic [2:0]  dv;
    logic [1:0]  dc;
    logic [15:0] per;
    logic [15:0] hi;
  } rco_row_s;
  localparam logic [31:0] AC = {18'h0, RCO_ADDR_CONTROL};
  localparam logic [31:0] AS = {18'h0, RCO_ADDR_SOURCE};
  logic        pclk, presetn, psel, penable, pwrite, sleep, pready, pslverr, pin, intl, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [11:0] src;
  logic [15:0] high_len, per_len, rises, r0;
  int          fail_count, checks, cnt [12];
  // Source i toggles every i+2 cycles; period and high time in pclk cycles
  rco_row_s    rows [12] = '{
    '{4'h0, 3'h0, 2'h1, 16'h0004, 16'h0002}, '{4'h1, 3'h1, 2'h2, 16'h000c, 16'h0006},
    '{4'h2, 3'h2, 2'h3, 16'h0020, 16'h0018}, '{4'h3, 3'h3, 2'h1, 16'h0050, 16'h0014},
    '{4'h4, 3'h4, 2'h2, 16'h00c0, 16'h0060}, '{4'h5, 3'h5, 2'h3, 16'h01c0, 16'h0150},
    '{4'h6, 3'h6, 2'h1, 16'h0400, 16'h0100}, '{4'h7, 3'h7, 2'h2, 16'h0900, 16'h0480},
    '{4'h8, 3'h0, 2'h3, 16'h0014, 16'h000a}, '{4'h9, 3'h1, 2'h1, 16'h002c, 16'h000b},
    '{4'ha, 3'h2, 2'h2, 16'h0060, 16'h0030}, '{4'hb, 3'h3, 2'h3, 16'h00d0, 16'h009c}};
  logic [7:0]  q_ctl [4] = '{8'h90, 8'h90, 8'h80, 8'h83};
  logic [3:0]  q_src [4] = '{4'hc, 4'hf, 4'h1, 4'h1};

  rco_ref_clock #(.CNT_W(8)) i_rco_ref_clock (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sleep(sleep), .system_osc(src[0]),
    .high_freq_internal_osc(src[1]), .low_freq_internal_osc(src[2]),
    .medium_freq_internal_osc_500k(src[3]), .medium_freq_internal_osc_32k(src[4]),
    .secondary_osc(src[5]), .external_osc(src[6]), .osc_controlled_output(src[7]),
    .logic_cell_one_output(src[8]), .logic_cell_two_output(src[9]),
    .logic_cell_three_output(src[10]), .logic_cell_four_output(src[11]),
    .ref_clock_out_pin(pin), .ref_clock_internal(intl));
  rco_load i_rco_load (.pclk(pclk), .presetn(presetn), .pin(pin), .internal(intl),
    .high_len(high_len), .per_len(per_len), .rises(rises));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Slow sources, all below pclk/2 so the block can follow them
  always @(posedge pclk) begin
    for (int i = 0; i < 12; i++) begin
      src[i] <= (cnt[i] == i + 1) ? ~src[i] : src[i];
      cnt[i] <= (cnt[i] == i + 1) ? 0 : cnt[i] + 1;
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic set(input logic [31:0] s, input logic [31:0] c);
    apb(1'b1, AC, 32'h0, 4'hf);
    apb(1'b1, AS, s, 4'hf);
    apb(1'b1, AC, c, 4'hf);
  endtask
  task automatic wait_rises(input int n);
    logic [15:0] r;
    r = rises;
    for (int k = 0; k < 12000 && (rises - r) < n; k++) @(posedge pclk);
    chk("rise wait", {31'h0, (rises - r) >= n}, 32'h1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, sleep, src} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      set({28'h0, rows[i].sel}, {24'h1, 1'b1, 2'h0, rows[i].dc, rows[i].dv} & 32'hff);
      wait_rises(3);
      chk("period", {16'h0, per_len}, {16'h0, rows[i].per});
      chk("high time", {16'h0, high_len}, {16'h0, rows[i].hi});
    end
    // Disable in mid high phase must cut the output at once
    set(32'h6, 32'h9f);
    wait_rises(1);
    repeat (100) @(posedge pclk);
    chk("pin mid period", {31'h0, pin}, 32'h1);
    apb(1'b0, AS, 32'h0, 4'hf);
    chk("source running", rd, 32'h86);
    apb(1'b1, AC, 32'h1f, 4'hf);
    // Output flop falls on the first edge after the write edge; checked at the second
    repeat (2) @(posedge pclk);
    chk("pin after disable", {31'h0, pin}, 32'h0);
    // Reserved sources and zero duty give no edges
    foreach (q_ctl[i]) begin
      set({28'h0, q_src[i]}, {24'h0, q_ctl[i]});
      r0 = rises;
      repeat (200) @(posedge pclk);
      chk("quiet edges", {16'h0, rises}, {16'h0, r0});
    end
    sleep <= 1'b1;
    set(32'h1, 32'h91);
    wait_rises(3);
    chk("sleep period", {16'h0, per_len}, 32'hc);
    set(32'h0, 32'h91);
    r0 = rises;
    repeat (100) @(posedge pclk);
    chk("sleep system edges", {16'h0, rises}, {16'h0, r0});
    sleep <= 1'b0;
    wait_rises(3);
    chk("system period", {16'h0, per_len}, 32'h8);
    // Second reset while running, then register map
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pin in reset", {31'h0, pin}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, AC, 32'h0, 4'hf);
    chk("control reset", rd, 32'h10);
    apb(1'b0, AS, 32'h0, 4'hf);
    chk("source reset", rd, 32'h0);
    apb(1'b0, 32'h0, 32'h0, 4'hf);
    chk("unmapped error", {31'h0, er}, 32'h1);
    apb(1'b1, AC, 32'h1b, 4'h0);
    apb(1'b0, AC, 32'h0, 4'hf);
    chk("strobe off write", rd, 32'h10);
    apb(1'b1, AC, 32'h1b, 4'hf);
    apb(1'b0, AC, 32'h0, 4'hf);
    chk("control readback", rd, 32'h1b);
    apb(1'b1, AS, 32'hb, 4'hf);
    apb(1'b0, AS, 32'h0, 4'hf);
    chk("source readback", {28'h0, rd[3:0]}, 32'hb);
    stop_test();
  end
endmodule // rco_ref_clock_test

bind rco_ref_clock rco_ref_clock_properties #(.CNT_W(CNT_W)) i_rco_ref_clock_properties (.*);
`default_nettype wire
